// ===== rsfc_fifo.sv
/*
 * rsfc_fifo: three-axis sample fifo with status, setup, control and data
 * registers on an AXI4-Lite slave.
 * assumes samples on sample_axes are valid whenever the timer ticks and
 * that software changes the setup only in standby.
 */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: status at address zero mirrors the fifo state report register.
// RULE2: entering active from standby or ready clears the fifo status.
// RULE3: overflow flag sets when count is 32 and another sample arrives.
// RULE4: overflow flag clears once the count drops below 32.
// RULE5: watermark flag sets while count is at or above the watermark.
// RULE6: watermark flag clears when count falls below the watermark.
// RULE7: count of stored samples reads in bits 5 to 0, zero empty.
// RULE8: samples are written at the rate selected in control register one.
// RULE9: host changes the fifo setup only while in standby.
// RULE10: mode field 00 disables, 01 circular, 1x stop.
// RULE11: circular mode at 32 samples drops the oldest for the newest.
// RULE12: stop mode refuses samples once 32 are stored.
// RULE13: host disables the fifo before switching circular and stop.
// RULE14: disabling empties the fifo and zeroes the count.
// RULE15: disabling clears the watermark flag.
// RULE16: watermark level zero never raises the watermark flag.
// RULE17: reaching the watermark does not block further samples.
// RULE18: watermark level resets to zero.
// RULE19: fifo event output is overflow or watermark flag.
// RULE20: reading the last axis pops the oldest sample, count minus one.
module rsfc_fifo #(
    parameter int FAST_PERIOD_CYC = rsfc_pkg::FAST_PERIOD_CYC
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // write address channel
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    // write data channel
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    // write response channel
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // read address channel
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    // read data channel
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // sample source and event
    input  wire rsfc_pkg::rsfc_sample_s sample_axes,
    output var  logic                   fifo_event
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic [5:0] word_index(input logic [7:0] a);
        return a[7:2];
    endfunction : word_index

    function automatic logic is_mapped(input logic [5:0] i);
        return (i == rsfc_pkg::IDX_STATUS) || (i == rsfc_pkg::IDX_DATA_X)
            || (i == rsfc_pkg::IDX_DATA_Y) || (i == rsfc_pkg::IDX_DATA_Z)
            || (i == rsfc_pkg::IDX_FIFO_STATE)
            || (i == rsfc_pkg::IDX_FIFO_CFG) || (i == rsfc_pkg::IDX_CTRL1);
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]             fifo_configuration;
    logic [7:0]             first_control_register;
    rsfc_pkg::rsfc_status_s status;
    rsfc_pkg::rsfc_sample_s store [32];
    logic [4:0]             wr_ptr;
    logic [4:0]             rd_ptr;
    logic [19:0]            rate_timer;
    logic [7:0]             aw_addr;
    logic                   aw_got;
    logic [7:0]             w_data;
    logic                   w_strb0;
    logic                   w_got;

    // ------------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------------
    rsfc_pkg::rsfc_fmode_e fmode;
    wire [1:0] mode_bits  = fifo_configuration[rsfc_pkg::MODE_HI:
                                               rsfc_pkg::MODE_LO];
    wire [5:0] watermark_level = fifo_configuration[rsfc_pkg::WMRK_HI:
                                                    rsfc_pkg::WMRK_LO];
    wire [2:0] output_rate_select = first_control_register[
                                    rsfc_pkg::RATE_HI:rsfc_pkg::RATE_LO];
    wire [1:0] op_state   = first_control_register[rsfc_pkg::OPST_HI:
                                                   rsfc_pkg::OPST_LO];
    wire       dev_active = op_state[1];

    assign fmode = (mode_bits == 2'b00) ? rsfc_pkg::FIFO_OFF      // RULE10
                 : (mode_bits == 2'b01) ? rsfc_pkg::FIFO_CIRCULAR
                 :                        rsfc_pkg::FIFO_STOP;
    wire fifo_on = (fmode != rsfc_pkg::FIFO_OFF);
    wire circ    = (fmode == rsfc_pkg::FIFO_CIRCULAR);

    // ------------------------------------------------------------------
    // output data rate timer
    // ------------------------------------------------------------------
    // codes above the slowest rate repeat the slowest rate
    wire [2:0]  rate_shift = (output_rate_select > rsfc_pkg::RATE_SLOW)
                           ? rsfc_pkg::RATE_SLOW : output_rate_select;
    wire [19:0] rate_last  = 20'((FAST_PERIOD_CYC << rate_shift) - 1);
    wire        rate_tick  = dev_active && (rate_timer >= rate_last); // RULE8
    wire [19:0] next_rate_timer = (!dev_active || rate_tick) ? 20'h0_0000
                                : rate_timer + 20'h0_0001;

    // ------------------------------------------------------------------
    // write path of the bus
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire commit  = aw_got && w_got && !s_axi_bvalid;
    wire [5:0] wr_idx = word_index(aw_addr);
    wire wr_cfg  = commit && w_strb0 && (wr_idx == rsfc_pkg::IDX_FIFO_CFG);
    wire wr_ctrl = commit && w_strb0 && (wr_idx == rsfc_pkg::IDX_CTRL1);
    // standby or ready into active
    wire go_active = wr_ctrl && !dev_active && w_data[rsfc_pkg::OPST_HI];
    wire next_aw_got = commit ? 1'b0 : (aw_got || aw_take);
    wire next_w_got  = commit ? 1'b0 : (w_got || w_take);
    wire next_bvalid = commit ? 1'b1
                     : (s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid;
    wire [1:0] next_bresp = commit ? (is_mapped(wr_idx) ? rsfc_pkg::RESP_OKAY
                                      : rsfc_pkg::RESP_SLVERR)
                          : s_axi_bresp;

    // ------------------------------------------------------------------
    // read path of the bus
    // ------------------------------------------------------------------
    wire        ar_take = s_axi_arvalid && s_axi_arready;
    wire [5:0]  rd_idx  = word_index(s_axi_araddr);
    wire [7:0]  status_byte = status;
    rsfc_pkg::rsfc_sample_s head;
    assign head = store[rd_ptr];
    wire [31:0] rd_word =
        (rd_idx == rsfc_pkg::IDX_STATUS)     ? {24'h00_0000, status_byte}
      : (rd_idx == rsfc_pkg::IDX_FIFO_STATE) ? {24'h00_0000, status_byte}
      : (rd_idx == rsfc_pkg::IDX_FIFO_CFG)   ? {24'h00_0000,
                                                fifo_configuration}
      : (rd_idx == rsfc_pkg::IDX_CTRL1)      ? {24'h00_0000,
                                                first_control_register}
      : (rd_idx == rsfc_pkg::IDX_DATA_X)     ? {16'h0000, head.x}
      : (rd_idx == rsfc_pkg::IDX_DATA_Y)     ? {16'h0000, head.y}
      : (rd_idx == rsfc_pkg::IDX_DATA_Z)     ? {16'h0000, head.z}
      :                                        32'h0000_0000;       // RULE1
    wire next_rvalid = ar_take ? 1'b1
                     : (s_axi_rvalid && s_axi_rready) ? 1'b0 : s_axi_rvalid;

    // ------------------------------------------------------------------
    // fifo bookkeeping
    // ------------------------------------------------------------------
    wire full     = (status.count == rsfc_pkg::DEPTH);
    wire pop      = ar_take && (rd_idx == rsfc_pkg::IDX_DATA_Z)
                 && (status.count != 6'h00) && fifo_on;             // RULE20
    wire push_req = rate_tick && fifo_on;
    // a pop in the same cycle makes room, so the new sample fits
    wire push_acc = push_req && (!full || pop || circ);  // RULE12 RULE17
    wire drop_old = push_req && full && !pop && circ;               // RULE11
    wire clear_all = !fifo_on || go_active;              // RULE2 RULE14

    logic [5:0] next_count;
    always_comb
    begin
        next_count = status.count;
        if (clear_all)
            next_count = 6'h00;
        else if (push_acc && !pop && !drop_old)
            next_count = status.count + 6'h01;
        else if (pop && !push_acc)
            next_count = status.count - 6'h01;                      // RULE20
    end

    wire ovf_set = push_req && full && !pop;                        // RULE3
    wire next_ovf = clear_all ? 1'b0
                  : ovf_set ? 1'b1
                  : (next_count < rsfc_pkg::DEPTH) ? 1'b0           // RULE4
                  : status.overflow;
    wire next_wmk = !clear_all && (watermark_level != 6'h00)  // RULE15 RULE16
                 && (next_count >= watermark_level);        // RULE5 RULE6

    wire [4:0] next_wr_ptr = clear_all ? 5'h00
                           : push_acc ? wr_ptr + 5'h01 : wr_ptr;
    wire [4:0] next_rd_ptr = clear_all ? 5'h00
                           : (pop || drop_old) ? rd_ptr + 5'h01 : rd_ptr;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fifo_configuration     <= rsfc_pkg::CFG_RESET;          // RULE18
            first_control_register <= rsfc_pkg::CTRL_RESET;
        end
        else
        begin
            if (wr_cfg)
                fifo_configuration <= w_data;
            if (wr_ctrl)
                first_control_register <= w_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status     <= '0;
            wr_ptr     <= 5'h00;
            rd_ptr     <= 5'h00;
            rate_timer <= 20'h0_0000;
            fifo_event <= 1'b0;
        end
        else
        begin
            status.overflow  <= next_ovf;
            status.watermark <= next_wmk;
            status.count     <= next_count;                         // RULE7
            wr_ptr           <= next_wr_ptr;
            rd_ptr           <= next_rd_ptr;
            rate_timer       <= next_rate_timer;
            fifo_event       <= next_ovf || next_wmk;               // RULE19
        end
    end

    // sample storage has no reset; the count guards only the pop, data reads show the slot at rd_ptr
    genvar g;
    generate
        for (g = 0; g < 32; g++)
        begin : g_slot
            always_ff @(posedge aclk)
            begin
                if (push_acc && !clear_all && (wr_ptr == 5'(g)))
                    store[g] <= sample_axes;                        // RULE8
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 8'h00;
            w_strb0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= rsfc_pkg::RESP_OKAY;
        end
        else
        begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            s_axi_awready <= !next_aw_got;
            s_axi_wready  <= !next_w_got;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            if (aw_take)
                aw_addr <= s_axi_awaddr;
            if (w_take)
            begin
                w_data  <= s_axi_wdata[7:0];
                w_strb0 <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= rsfc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take)
            begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= is_mapped(rd_idx) ? rsfc_pkg::RESP_OKAY
                                                 : rsfc_pkg::RESP_SLVERR;
            end
        end
    end

endmodule : rsfc_fifo
`default_nettype wire

// ===== rsfc_fifo_checker.sv
/*
 * rsfc_fifo_checker: read channel and status assertions for rsfc_fifo.
 * assumes it is bound to rsfc_fifo and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module rsfc_fifo_checker #(
    parameter int FAST_PERIOD_CYC = rsfc_pkg::FAST_PERIOD_CYC
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // read channels
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ------------------------------------------------------------------
    // index of the read in flight
    // ------------------------------------------------------------------
    logic [5:0] rd_idx;
    wire        is_stat = rd_idx == 6'h00 || rd_idx == 6'h08;
    wire        is_map  = rd_idx inside {6'h00, 6'h01, 6'h02, 6'h03,
                                         6'h08, 6'h09, 6'h13};

    always_ff @(posedge aclk)
        if (s_axi_arvalid && s_axi_arready)
            rd_idx <= s_axi_araddr[7:2];

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence stat_out;
        s_axi_rvalid && is_stat;
    endsequence

    read_lat_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before handshake");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    stat_width_a: assert property (stat_out |->
        s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[5:0] <= 6'h20)
        else $error("status count field out of range");
    ovf_full_a: assert property ((stat_out and s_axi_rdata[7]) |->
        s_axi_rdata[5:0] == 6'h20)
        else $error("overflow flag with count below full");
    wmk_level_a: assert property ((stat_out and s_axi_rdata[6]) |->
        s_axi_rdata[5:0] != 6'h00)
        else $error("watermark flag with empty fifo");
    bad_addr_a: assert property (s_axi_rvalid && !is_map |->
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    ok_addr_a: assert property (s_axi_rvalid && is_map |->
        s_axi_rresp == 2'h0)
        else $error("mapped read refused");
endmodule : rsfc_fifo_checker

bind rsfc_fifo rsfc_fifo_checker #(.FAST_PERIOD_CYC(FAST_PERIOD_CYC)) chk (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== rsfc_host.sv
/*
 * rsfc_host: AXI4-Lite master standing in for the host processor.
 * assumes the bench calls wr and rd one at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module rsfc_host (
    // clock
    input  wire logic        aclk,
    // write channels
    output var  logic [7:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // read channels
    output var  logic [7:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    // every other read holds rready back until rvalid shows
    bit rd_slow = 1'b0;

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        s_axi_wstrb = 4'hf;
    end

    // released payloads are inverted so nothing reads a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      output logic [1:0] r);
        bit busy;
        busy = 1'b1;
        repeat (2) @(posedge aclk);
        {s_axi_awvalid, s_axi_awaddr} <= {1'b1, a};
        {s_axi_wvalid, s_axi_wdata} <= {1'b1, 24'h00_0000, v};
        s_axi_bready <= 1'b1;
        while (busy)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wvalid && s_axi_wready)
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~s_axi_wdata};
            if (s_axi_bvalid)
                {r, busy} = {s_axi_bresp, 1'b0};
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        bit busy;
        busy = 1'b1;
        repeat (2) @(posedge aclk);
        {s_axi_arvalid, s_axi_araddr, s_axi_rready} <= {1'b1, a, !rd_slow};
        while (busy)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if (s_axi_rvalid && s_axi_rready)
                {d, r, busy} = {s_axi_rdata, s_axi_rresp, 1'b0};
            else if (s_axi_rvalid)
                s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        rd_slow = !rd_slow;
    endtask : rd
endmodule : rsfc_host
`default_nettype wire

// ===== rsfc_pkg.sv
/*
 * rsfc_pkg: constants and carrier types of the rate sample fifo control.
 * assumes a 10 MHz aclk and 32-bit AXI4-Lite register access.
 */
package rsfc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_STATUS     = 6'h00;
    localparam logic [5:0] IDX_DATA_X     = 6'h01;
    localparam logic [5:0] IDX_DATA_Y     = 6'h02;
    localparam logic [5:0] IDX_DATA_Z     = 6'h03;
    localparam logic [5:0] IDX_FIFO_STATE = 6'h08;
    localparam logic [5:0] IDX_FIFO_CFG   = 6'h09;
    localparam logic [5:0] IDX_CTRL1      = 6'h13;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int         MODE_HI    = 7;
    localparam int         MODE_LO    = 6;
    localparam int         WMRK_HI    = 5;
    localparam int         WMRK_LO    = 0;
    localparam int         RATE_HI    = 4;
    localparam int         RATE_LO    = 2;
    localparam int         OPST_HI    = 1;
    localparam int         OPST_LO    = 0;
    localparam logic [7:0] CFG_RESET  = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] DEPTH      = 6'h20;
    localparam logic [2:0] RATE_SLOW  = 3'h6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // timing: fastest output data rate period, slower rates are doubled
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int FAST_PERIOD_NS = 1250000;
    localparam int FAST_PERIOD_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FIFO_OFF,
        FIFO_CIRCULAR,
        FIFO_STOP
    } rsfc_fmode_e;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } rsfc_sample_s;

    typedef struct packed {
        logic       overflow;
        logic       watermark;
        logic [5:0] count;
    } rsfc_status_s;

endpackage : rsfc_pkg

// ===== rsfc_tb.sv
/*
 * testbench: fills, drains, disables and re-arms the sample fifo.
 * assumes the fast output period is shortened to 8 clocks.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end end
module testbench;
    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic [7:0]             s_axi_awaddr, s_axi_araddr;
    logic [31:0]            s_axi_wdata, s_axi_rdata, d;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp, r;
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                   s_axi_rready, fifo_event;
    logic [5:0]             wm;
    rsfc_pkg::rsfc_sample_s sample_axes = '0;
    integer                 seed = 32'heb78_0854;
    int                     num_errors = 0;
    int                     n_compared = 0;
    int                     cyc = 0;
    int                     t0;

    rsfc_fifo #(.FAST_PERIOD_CYC(8)) uut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sample_axes, .fifo_event);
    rsfc_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial forever #50 aclk = ~aclk;
    // z carries the cycle so the order of kept samples can be told
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        sample_axes <= rsfc_pkg::rsfc_sample_s'({$random(seed), 16'(cyc)});
    end

    function automatic logic [7:0] exp_st(int cnt, int lvl, logic ovf);
        return {ovf, lvl != 0 && cnt >= lvl, 6'(cnt)};
    endfunction : exp_st

    // flags only settle once the timer is stopped in standby
    task automatic stat(input logic [7:0] e);
        host.rd(8'h20, d, r);
        `CHK(d, {24'h00_0000, e})
        host.rd(8'h00, d, r);
        `CHK(d, {24'h00_0000, e})
        `CHK(fifo_event, e[7] | e[6])
    endtask : stat

    task automatic conclude();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (30000) @(posedge aclk);
        num_errors++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        host.rd(8'h24, d, r);
        `CHK(d, 32'h0000_0000)
        stat(8'h00);
        host.rd(8'h10, d, r);
        `CHK(r, rsfc_pkg::RESP_SLVERR)
        host.wr(8'h10, 8'hff, r);
        `CHK(r, rsfc_pkg::RESP_SLVERR)
        host.wr(8'h20, 8'h5a, r);
        stat(8'h00);
        for (int i = 0; i < 3; i++)
        begin
            wm = 6'(2 + {$random(seed)} % 30);
            host.wr(8'h24, {2'(i + 1), wm}, r);
            host.wr(8'h4c, 8'h02, r);
            t0 = cyc;
            repeat (320) @(posedge aclk);
            host.wr(8'h4c, 8'h00, r);
            stat(exp_st(32, wm, 1'b1));
            for (int c = 31; c >= int'(wm) - (i == 0 ? 1 : 0); c--)
            begin
                host.rd(8'h0c, d, r);
                // stop keeps the first samples, circular the latest ones
                if (c == 31)
                    `CHK(d[15:0] < 16'(t0 + 40), i != 0)
                stat(exp_st(c, wm, 1'b0));
            end
            if (i == 1)
            begin
                host.wr(8'h4c, 8'h01, r);
                host.wr(8'h4c, 8'h02, r);
                host.wr(8'h4c, 8'h00, r);
                stat(8'h00);
            end
            host.wr(8'h24, {2'b00, wm}, r);
            stat(8'h00);
        end
        host.wr(8'h24, 8'h40, r);
        host.wr(8'h4c, 8'h06, r);
        repeat (320) @(posedge aclk);
        host.wr(8'h4c, 8'h00, r);
        host.rd(8'h20, d, r);
        `CHK(d[7:6], 2'b00)
        `CHK(d[5:0] inside {[6'h13:6'h15]}, 1'b1)
        conclude();
    end
endmodule : testbench
`default_nettype wire
